//--- shared/smc_pkg.sv
// smc_pkg: register offsets, field positions, reset values and counts shared by the
// stand-alone / control-port configuration controller.
// assumes a 32-bit apb register bus and a 25 MHz system clock.
package smc_pkg;
  // apb register map (byte addresses)
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_POINTER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BYTE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
  // control word field positions
  localparam int unsigned CONTROL_PORT_ENABLE_BIT_BIT = 0;
  localparam int unsigned PDN_BIT = 1;
  localparam int unsigned FILT_BIT = 2;
  localparam int unsigned MDIV_BIT = 3;
  localparam int unsigned FM_LSB = 4;
  localparam int unsigned FMT_LSB = 6;
  localparam int unsigned DEM_BIT = 9;
  localparam int unsigned SRC_LSB = 10;
  localparam int unsigned MUTE_CONTROL_BITS_LSB = 13;
  localparam int unsigned RATIO_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  localparam logic [31:0] CTRL_WMASK = 32'h0007_7FFE;
  localparam logic [31:0] CONTROL_PORT_ENABLE_BIT_MASK = 32'h0000_0001;
  // register pointer
  localparam int unsigned PTR_STEP_BIT = 7;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] PTR_WMASK = 8'h9F;
  localparam logic [4:0] PTR_FIRST_A = 5'h01;
  localparam logic [4:0] PTR_LAST_A = 5'h08;
  localparam logic [4:0] PTR_LAST_B = 5'h11;
  // speed codes, function mode codes, master clock ratio select
  localparam logic [1:0] SPEED_SINGLE = 2'h0;
  localparam logic [1:0] SPEED_DOUBLE = 2'h1;
  localparam logic [1:0] SPEED_QUAD = 2'h2;
  localparam logic [1:0] FM_STREAM = 2'h3;
  localparam logic [2:0] RATIO_TOP = 3'h4;
  // oversampling ratios
  localparam logic [7:0] OSR_SINGLE = 8'h80;
  localparam logic [7:0] OSR_DOUBLE = 8'h40;
  localparam logic [7:0] OSR_QUAD = 8'h20;
  localparam logic [7:0] OSR_STREAM_LO = 8'h40;
  localparam logic [7:0] OSR_STREAM_HI = 8'h80;
  // power-up length in frame clock periods
  localparam logic [11:0] PWRUP_SINGLE = 12'h200;
  localparam logic [11:0] PWRUP_DOUBLE = 12'h400;
  localparam logic [11:0] PWRUP_QUAD = 12'h800;
  // timing counts in system clock cycles
  localparam logic [11:0] STREAM_HOLD_CYCLES = 12'h100;
  localparam logic [11:0] PERIOD_MAX = 12'hFFF;
  localparam logic [7:0] RETIME_CYCLES = 8'h80;
  // power sequencer states
  typedef enum logic [2:0] {
    SEQ_SA_POWERUP,
    SEQ_SA_RUN,
    SEQ_CP_HOLD,
    SEQ_CP_POWERUP,
    SEQ_CP_RUN
  } smc_seq_type;
endpackage : smc_pkg

//--- src/smc_config_ctrl.sv
// smc_config_ctrl: strap decode, power sequencing, control-port hand-over, clock pair
// selection with retime muting, and register pointer stepping for a six-channel dac.
// assumes strap and audio clock pins are already synchronous to i_clk, and an apb master.
//
// How it works
// [RULE_01] stand-alone: cfg pins 1:0 pick left-justified, i2s, right-justified 16 or 24.
// [RULE_02] stand-alone: cfg pins 3:2 pick single, single with de-emphasis, double, quad.
// [RULE_03] oversampling is 128x single, 64x double, 32x quad.
// [RULE_04] stand-alone: frame clock 1 held high selects stream mode, rate from pins 2:0.
// [RULE_05] stream codes 000 to 011 give 64x data at 4x, 6x, 8x, 12x ratios.
// [RULE_06] stream codes 100 to 111 give 128x data at 2x, 3x, 4x, 6x ratios.
// [RULE_07] top master clock ratio only valid in control-port mode with divide bit set.
// [RULE_08] during reset all settings take defaults and the quiescent reference stays low.
// [RULE_09] after reset, low power while the stand-alone power-up counts 512/1024/2048 frames.
// [RULE_10] writing the enable bit stops stand-alone power-up and loads control defaults.
// [RULE_11] control writes are taken any time after reset; enable early to avoid clicks.
// [RULE_12] host loads settings with power-down set; clearing it starts power-up.
// [RULE_13] fast or slow filter by select bit; stand-alone always uses the fast one.
// [RULE_14] control-port mode: each data input uses its selected clock pair.
// [RULE_15] both pairs used and sync lost: retime, dacs inactive, outputs and mute pins muted.
// [RULE_16] stand-alone: every dac pair is timed from clock pair 1 only.
// [RULE_17] the source derives both frame clocks from one master clock; unused pair low.
// [RULE_18] control-port mode: function mode bits select stream, rate from format field.
// [RULE_19] pointer holds when step bit clear, else steps 01h-08h and 09h-11h separately.
// [RULE_20] once enabled, strap pins are ignored and control registers rule.
// [RULE_21] control accesses are independent of the audio sample rate.
// [RULE_22] pointer: step enable bit 7, address bits 4:0, both reset to zero.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module smc_config_ctrl
  import smc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // strap pins
  input wire logic i_cfg_pin_0,
  input wire logic i_cfg_pin_1,
  input wire logic i_cfg_pin_2,
  input wire logic i_cfg_pin_3,
  // serial audio clock pins
  input wire logic i_frame_clock_1,
  input wire logic i_frame_clock_2,
  input wire logic i_bit_clock_1,
  input wire logic i_bit_clock_2,
  // decoded settings
  output logic o_cp_mode,
  output logic [2:0] o_format_code,
  output logic [1:0] o_speed,
  output logic o_de_emphasis,
  output logic [7:0] o_osr,
  output logic o_stream_active,
  output logic [7:0] o_stream_osr,
  output logic [3:0] o_stream_ratio,
  output logic o_filter_slow,
  output logic o_ratio_error,
  output logic [7:0] o_pointer,
  // power and mute
  output logic o_low_power,
  output logic o_quiescent_reference,
  output logic o_dac_active,
  output logic o_mute,
  output logic o_mute_pin,
  // per data input clock selection
  output logic [2:0] o_data_bit_clock,
  output logic [2:0] o_data_frame_clock
);

  // speed from the two strap pins
  function automatic logic [1:0] sa_speed(input logic [1:0] code);
    sa_speed = code[1] ? (code[0] ? SPEED_QUAD : SPEED_DOUBLE) : SPEED_SINGLE;
  endfunction : sa_speed

  // register decode shared by read and write paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  logic [31:0] ctrl_reg;
  logic [7:0] ptr_reg;
  smc_seq_type seq_reg;
  logic [11:0] frame_cnt_reg;
  logic fc1_prev_reg;
  logic fc2_prev_reg;
  logic [11:0] hold_cnt_reg;
  logic stream_pin_reg;
  logic [7:0] retime_cnt_reg;
  logic [11:0] period_cnt_reg [2];
  logic [11:0] period_last_reg [2];
  logic [1:0] period_valid_reg;
  logic [1:0] sync_lost;
  logic [1:0] fc_rise;
  logic apb_setup;
  logic apb_write;
  logic control_port_enable_bit_set;
  logic cp_mode;
  logic [1:0] speed_next;
  logic dem_next;
  logic stream_next;
  logic [2:0] stream_code;
  logic [2:0] format_next;
  logic [2:0] src_sel;
  logic pair2_used;
  logic retiming;
  logic [11:0] pwrup_target;
  logic [31:0] status_word;

  assign cp_mode = ctrl_reg[CONTROL_PORT_ENABLE_BIT_BIT];
  assign apb_setup = i_psel & ~i_penable & ~o_pready;
  assign apb_write = i_psel & i_penable & o_pready & i_pwrite;
  // the enable write is recognised on the rising of the bit only
  assign control_port_enable_bit_set = apb_write & reg_hit(i_paddr, OFS_CTRL) & i_pwdata[CONTROL_PORT_ENABLE_BIT_BIT] & ~cp_mode;
  assign fc_rise = {i_frame_clock_2 & ~fc2_prev_reg, i_frame_clock_1 & ~fc1_prev_reg};

  // effective settings: straps before enable, registers after
  always_comb begin
    if (cp_mode) begin // [RULE_20]
      speed_next = (ctrl_reg[FM_LSB +: 2] == FM_STREAM) ? SPEED_SINGLE : ctrl_reg[FM_LSB +: 2];
      dem_next = ctrl_reg[DEM_BIT];
      stream_next = (ctrl_reg[FM_LSB +: 2] == FM_STREAM); // [RULE_18]
      stream_code = ctrl_reg[FMT_LSB +: 3];
      format_next = ctrl_reg[FMT_LSB +: 3];
      src_sel = ctrl_reg[SRC_LSB +: 3]; // [RULE_14]
    end else begin
      speed_next = sa_speed({i_cfg_pin_3, i_cfg_pin_2}); // [RULE_02]
      dem_next = ({i_cfg_pin_3, i_cfg_pin_2} == 2'h1);
      stream_next = stream_pin_reg; // [RULE_04]
      stream_code = {i_cfg_pin_2, i_cfg_pin_1, i_cfg_pin_0};
      format_next = {1'b0, i_cfg_pin_1, i_cfg_pin_0}; // [RULE_01]
      src_sel = 3'h0; // [RULE_16]
    end
  end

  // power-up length follows the active speed
  always_comb begin
    case (speed_next)
      SPEED_DOUBLE: pwrup_target = PWRUP_DOUBLE; // [RULE_09]
      SPEED_QUAD: pwrup_target = PWRUP_QUAD;
      default: pwrup_target = PWRUP_SINGLE;
    endcase
  end

  assign pair2_used = cp_mode & (|src_sel);
  assign retiming = (retime_cnt_reg != 8'h00);
  assign status_word = {8'h00, o_osr, 5'h00, o_ratio_error, retiming, o_format_code,
                        o_speed, o_stream_active, o_quiescent_reference, o_low_power, cp_mode};

  // apb slave: one wait-free access phase, answer prepared during setup
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_setup;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      if (apb_setup) begin
        if (reg_hit(i_paddr, OFS_CTRL))
          o_prdata <= ctrl_reg;
        else if (reg_hit(i_paddr, OFS_POINTER))
          o_prdata <= {24'h00_0000, ptr_reg};
        else if (reg_hit(i_paddr, OFS_STATUS))
          o_prdata <= status_word;
        else if (!reg_hit(i_paddr, OFS_BYTE))
          o_pslverr <= 1'b1;
      end
    end
  end

  // control word; writes land any time after reset; before enable only the ratio field and mute bit 0 take effect
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_reg <= CTRL_RESET; // [RULE_08]
    end else if (control_port_enable_bit_set) begin
      ctrl_reg <= CTRL_RESET | CONTROL_PORT_ENABLE_BIT_MASK; // [RULE_10]
    end else if (apb_write && reg_hit(i_paddr, OFS_CTRL)) begin
      ctrl_reg <= (i_pwdata & CTRL_WMASK) | (ctrl_reg & CONTROL_PORT_ENABLE_BIT_MASK); // [RULE_11] [RULE_21]
    end
  end

  // register pointer with two separate stepping blocks
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ptr_reg <= POINTER_RESET; // [RULE_22]
    end else if (apb_write && reg_hit(i_paddr, OFS_POINTER)) begin
      ptr_reg <= i_pwdata[7:0] & PTR_WMASK;
    end else if (apb_write && reg_hit(i_paddr, OFS_BYTE) && ptr_reg[PTR_STEP_BIT]) begin
      // the step stops at the end of each block rather than crossing into the next
      if (ptr_reg[4:0] >= PTR_FIRST_A && ptr_reg[4:0] < PTR_LAST_B &&
          ptr_reg[4:0] != PTR_LAST_A)
        ptr_reg[4:0] <= ptr_reg[4:0] + 5'h01; // [RULE_19]
    end
  end

  // stream request: frame clock 1 must sit high for a while, so pcm framing never trips it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fc1_prev_reg <= 1'b0;
      fc2_prev_reg <= 1'b0;
      hold_cnt_reg <= 12'h000;
      stream_pin_reg <= 1'b0;
    end else begin
      fc1_prev_reg <= i_frame_clock_1;
      fc2_prev_reg <= i_frame_clock_2;
      if (!i_frame_clock_1) begin
        hold_cnt_reg <= 12'h000;
        stream_pin_reg <= 1'b0;
      end else if (hold_cnt_reg == STREAM_HOLD_CYCLES) begin
        stream_pin_reg <= 1'b1; // [RULE_04]
      end else begin
        hold_cnt_reg <= hold_cnt_reg + 12'h001;
      end
    end
  end

  // frame period watch per clock pair; a changed or stalled period means lost sync
  for (genvar p = 0; p < 2; p++) begin : g_period
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        period_cnt_reg[p] <= 12'h000;
        period_last_reg[p] <= 12'h000;
        period_valid_reg[p] <= 1'b0;
      end else if (fc_rise[p]) begin
        period_cnt_reg[p] <= 12'h001;
        period_last_reg[p] <= period_cnt_reg[p];
        period_valid_reg[p] <= 1'b1;
      end else if (period_cnt_reg[p] != PERIOD_MAX) begin
        period_cnt_reg[p] <= period_cnt_reg[p] + 12'h001;
      end
    end
    assign sync_lost[p] = period_valid_reg[p] &
                          ((fc_rise[p] & (period_cnt_reg[p] != period_last_reg[p])) |
                           (period_cnt_reg[p] == PERIOD_MAX));
  end

  // retime window restarts on every loss while both pairs are in use
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      retime_cnt_reg <= 8'h00;
    end else if (pair2_used && (|sync_lost)) begin
      retime_cnt_reg <= RETIME_CYCLES; // [RULE_15]
    end else if (retiming) begin
      retime_cnt_reg <= retime_cnt_reg - 8'h01;
    end
  end

  // power sequencer counted in frame clock 1 periods
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      seq_reg <= SEQ_SA_POWERUP;
      frame_cnt_reg <= 12'h000;
    end else if (control_port_enable_bit_set) begin
      seq_reg <= SEQ_CP_HOLD; // [RULE_10]
      frame_cnt_reg <= 12'h000;
    end else begin
      case (seq_reg)
        SEQ_SA_POWERUP, SEQ_CP_POWERUP: begin
          if (seq_reg == SEQ_CP_POWERUP && ctrl_reg[PDN_BIT]) begin
            seq_reg <= SEQ_CP_HOLD;
            frame_cnt_reg <= 12'h000;
          end else if (frame_cnt_reg >= pwrup_target) begin
            seq_reg <= (seq_reg == SEQ_SA_POWERUP) ? SEQ_SA_RUN : SEQ_CP_RUN; // [RULE_09]
          end else if (fc_rise[0]) begin
            frame_cnt_reg <= frame_cnt_reg + 12'h001;
          end
        end
        SEQ_CP_HOLD: begin
          frame_cnt_reg <= 12'h000;
          if (!ctrl_reg[PDN_BIT])
            seq_reg <= SEQ_CP_POWERUP; // [RULE_12]
        end
        SEQ_CP_RUN: begin
          if (ctrl_reg[PDN_BIT])
            seq_reg <= SEQ_CP_HOLD;
        end
        SEQ_SA_RUN: seq_reg <= SEQ_SA_RUN;
        default: seq_reg <= SEQ_SA_POWERUP;
      endcase
    end
  end

  // registered settings outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cp_mode <= 1'b0;
      o_format_code <= 3'h0;
      o_speed <= SPEED_SINGLE;
      o_de_emphasis <= 1'b0;
      o_osr <= OSR_SINGLE;
      o_stream_active <= 1'b0;
      o_stream_osr <= OSR_STREAM_LO;
      o_stream_ratio <= 4'h4;
      o_filter_slow <= 1'b0;
      o_ratio_error <= 1'b0;
      o_pointer <= POINTER_RESET;
    end else begin
      o_cp_mode <= cp_mode;
      o_format_code <= format_next;
      o_speed <= speed_next;
      o_de_emphasis <= dem_next;
      case (speed_next)
        SPEED_DOUBLE: o_osr <= OSR_DOUBLE; // [RULE_03]
        SPEED_QUAD: o_osr <= OSR_QUAD;
        default: o_osr <= OSR_SINGLE;
      endcase
      o_stream_active <= stream_next;
      o_stream_osr <= stream_code[2] ? OSR_STREAM_HI : OSR_STREAM_LO; // [RULE_05] [RULE_06]
      case (stream_code)
        3'h0: o_stream_ratio <= 4'h4; // [RULE_05]
        3'h1: o_stream_ratio <= 4'h6;
        3'h2: o_stream_ratio <= 4'h8;
        3'h3: o_stream_ratio <= 4'hC;
        3'h4: o_stream_ratio <= 4'h2; // [RULE_06]
        3'h5: o_stream_ratio <= 4'h3;
        3'h6: o_stream_ratio <= 4'h4;
        default: o_stream_ratio <= 4'h6;
      endcase
      o_filter_slow <= cp_mode & ctrl_reg[FILT_BIT]; // [RULE_13]
      o_ratio_error <= (ctrl_reg[RATIO_LSB +: 3] == RATIO_TOP) &
                       ~(cp_mode & ctrl_reg[MDIV_BIT]); // [RULE_07]
      o_pointer <= ptr_reg;
    end
  end

  // power, mute and mute pin; mute bit 1 disables the pin, bit 0 sets its active level
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_low_power <= 1'b1;
      o_quiescent_reference <= 1'b0; // [RULE_08]
      o_dac_active <= 1'b0;
      o_mute <= 1'b1;
      o_mute_pin <= 1'b0;
    end else begin
      o_low_power <= (seq_reg != SEQ_SA_RUN) && (seq_reg != SEQ_CP_RUN);
      o_quiescent_reference <= (seq_reg == SEQ_SA_RUN) || (seq_reg == SEQ_CP_RUN);
      o_dac_active <= ((seq_reg == SEQ_SA_RUN) || (seq_reg == SEQ_CP_RUN)) && !retiming;
      o_mute <= !(((seq_reg == SEQ_SA_RUN) || (seq_reg == SEQ_CP_RUN)) && !retiming);
      o_mute_pin <= (retiming && !ctrl_reg[MUTE_CONTROL_BITS_LSB + 1]) ?
                    ctrl_reg[MUTE_CONTROL_BITS_LSB] : ~ctrl_reg[MUTE_CONTROL_BITS_LSB]; // [RULE_15]
    end
  end

  // clock pair per data input; stand-alone forces pair 1
  for (genvar d = 0; d < 3; d++) begin : g_clk_sel
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        o_data_bit_clock[d] <= 1'b0;
        o_data_frame_clock[d] <= 1'b0;
      end else begin
        o_data_bit_clock[d] <= src_sel[d] ? i_bit_clock_2 : i_bit_clock_1; // [RULE_14]
        o_data_frame_clock[d] <= src_sel[d] ? i_frame_clock_2 : i_frame_clock_1; // [RULE_16]
      end
    end
  end

  a_sa_format: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_01]
    (!$past(i_reset) && !$past(cp_mode)) |->
      o_format_code == {1'b0, $past(i_cfg_pin_1), $past(i_cfg_pin_0)})
    else $error("strap format decode wrong");
  a_sa_dem_speed: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_02]
    (!$past(i_reset) && !$past(cp_mode) && $past({i_cfg_pin_3, i_cfg_pin_2}) == 2'h1) |->
      (o_de_emphasis && o_speed == SPEED_SINGLE))
    else $error("de-emphasis strap decode wrong");
  a_osr_speed: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_03]
    (o_speed == SPEED_QUAD) |-> (o_osr == OSR_QUAD))
    else $error("quad speed oversampling wrong");
  a_stream_lo: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_05]
    (!$past(i_reset) && $past(stream_code) == 3'h3) |-> (o_stream_ratio == 4'hC))
    else $error("stream ratio for code 3 wrong");
  a_top_ratio: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_07]
    (!$past(i_reset) && $past(ctrl_reg[RATIO_LSB +: 3]) == RATIO_TOP && !$past(cp_mode))
      |-> o_ratio_error)
    else $error("top ratio allowed outside control mode");
  a_reset_quiet: assert property (@(posedge i_clk) // [RULE_08]
    $past(i_reset) |-> (!o_quiescent_reference && ctrl_reg == CTRL_RESET))
    else $error("reset defaults not held");
  a_control_port_enable_bit_halts: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_10]
    control_port_enable_bit_set |=> (seq_reg == SEQ_CP_HOLD && ctrl_reg[PDN_BIT] && cp_mode))
    else $error("enable write did not halt power-up");
  a_pdn_start: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_12]
    (seq_reg == SEQ_CP_HOLD && !ctrl_reg[PDN_BIT] && !control_port_enable_bit_set) |=> seq_reg == SEQ_CP_POWERUP)
    else $error("power-down clear did not start power-up");
  a_retime_mute: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_15]
    retiming |=> (o_mute && !o_dac_active))
    else $error("retime without mute");
  a_ptr_block: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_19]
    (apb_write && reg_hit(i_paddr, OFS_BYTE) && ptr_reg == 8'h88) |=> ptr_reg == 8'h88)
    else $error("pointer crossed block boundary");
  a_sa_pair1: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_16]
    (!$past(i_reset) && !$past(cp_mode)) |-> o_data_frame_clock == {3{$past(i_frame_clock_1)}})
    else $error("stand-alone used clock pair 2");

endmodule : smc_config_ctrl

//--- dv/smc_clock_source.sv
// smc_clock_source: serial audio clock source model for the configuration controller bench.
// assumes i_clk stands for the master clock; outputs change just after its rising edge.
`timescale 1ns/1ps
module smc_clock_source (
  // master clock
  input wire logic i_clk,
  // scenario controls
  input wire logic i_hold_high,
  input wire logic i_pair2_on,
  input wire logic i_glitch,
  // clock pins
  output logic o_frame_clock_1,
  output logic o_frame_clock_2,
  output logic o_bit_clock_1,
  output logic o_bit_clock_2
);
  logic [4:0] count_reg = 5'h00;

  // one divider feeds both pairs so the frame clocks stay exact multiples
  // a glitch skips two counts once; holding frame clock 1 high or turning pair 2 off also breaks sync
  always_ff @(posedge i_clk) begin
    count_reg <= count_reg + (i_glitch ? 5'h03 : 5'h01);
  end

  // frame clock 1 doubles as the stream enable level while held high
  always_ff @(posedge i_clk) begin
    o_frame_clock_1 <= i_hold_high | count_reg[3];
    o_bit_clock_1 <= count_reg[0];
    o_frame_clock_2 <= i_pair2_on & count_reg[4]; // unused pair rests low
    o_bit_clock_2 <= i_pair2_on & count_reg[1];
  end
endmodule : smc_clock_source

//--- dv/tb.sv
// tb: self-checking bench for smc_config_ctrl, apb host tasks and a modelled clock source.
// assumes an apb slave that answers in its own time and strap pins seen as plain levels.
`timescale 1ns/1ps
module tb;
  import smc_pkg::*;
  localparam int FR = 16; // system clocks per frame clock 1 period
  logic i_clk = 1'b0, i_reset = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic i_cfg_pin_0 = 1'b0, i_cfg_pin_1 = 1'b0, i_cfg_pin_2 = 1'b0, i_cfg_pin_3 = 1'b0;
  logic hold_high = 1'b0, glitch = 1'b0, err;
  logic i_frame_clock_1, i_frame_clock_2, i_bit_clock_1, i_bit_clock_2;
  logic o_pready, o_pslverr, o_cp_mode, o_de_emphasis, o_stream_active, o_filter_slow;
  logic o_ratio_error, o_low_power, o_quiescent_reference, o_dac_active, o_mute, o_mute_pin;
  logic [2:0] o_format_code, o_data_bit_clock, o_data_frame_clock;
  logic [1:0] o_speed;
  logic [7:0] o_osr, o_stream_osr, o_pointer;
  logic [3:0] o_stream_ratio, pins_q;
  logic [3:0] ratio_tab [8] = '{4'h4, 4'h6, 4'h8, 4'hC, 4'h2, 4'h3, 4'h4, 4'h6};
  wire [3:0] flags = {o_low_power, o_dac_active, o_mute, o_quiescent_reference};
  int fail_count = 0, cmp_count = 0;

  smc_config_ctrl dut (.i_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_cfg_pin_0, .i_cfg_pin_1, .i_cfg_pin_2, .i_cfg_pin_3,
    .i_frame_clock_1, .i_frame_clock_2, .i_bit_clock_1, .i_bit_clock_2, .o_cp_mode,
    .o_format_code, .o_speed, .o_de_emphasis, .o_osr, .o_stream_active, .o_stream_osr,
    .o_stream_ratio, .o_filter_slow, .o_ratio_error, .o_pointer, .o_low_power,
    .o_quiescent_reference, .o_dac_active, .o_mute, .o_mute_pin, .o_data_bit_clock,
    .o_data_frame_clock);
  // pair 2 always runs here so that ignoring it in stand-alone mode is visible
  smc_clock_source src (.i_clk, .i_hold_high(hold_high), .i_pair2_on(1'b1), .i_glitch(glitch),
    .o_frame_clock_1(i_frame_clock_1), .o_frame_clock_2(i_frame_clock_2),
    .o_bit_clock_1(i_bit_clock_1), .o_bit_clock_2(i_bit_clock_2));

  // clock and a copy of the clock pins as the controller samples them
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    pins_q <= {i_frame_clock_1, i_frame_clock_2, i_bit_clock_1, i_bit_clock_2};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // waits whole cycles, then steps past the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc

  task automatic wait_flag(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (flags[b] !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_flag

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    #1;
  endtask : apb

  task automatic set_pins(input logic [3:0] v);
    @(posedge i_clk);
    {i_cfg_pin_3, i_cfg_pin_2, i_cfg_pin_1, i_cfg_pin_0} <= v;
  endtask : set_pins

  task automatic do_reset();
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
  endtask : do_reset

  task automatic check_stream(input int k);
    chk(o_stream_active, 1'b1);
    chk(o_stream_osr, (k < 4) ? OSR_STREAM_LO : OSR_STREAM_HI);
    chk(o_stream_ratio, ratio_tab[k]);
  endtask : check_stream

  // pointer loaded, stepped by n byte writes, then read back
  task automatic ptr_run(input logic [7:0] p, input int n, input logic [7:0] exp);
    apb(1'b1, OFS_POINTER, {24'h0, p});
    repeat (n) apb(1'b1, OFS_BYTE, 32'h0);
    apb(1'b0, OFS_POINTER, 32'h0);
    chk(rd, {24'h0, exp});
    chk(o_pointer, exp);
  endtask : ptr_run

  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // watchdog: the sequence needs about 30000 cycles
  initial begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    cyc(7);
    chk(o_quiescent_reference, 1'b0);
    @(posedge i_clk);
    i_reset <= 1'b0;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b0, OFS_POINTER, 32'h0);
    chk(rd, {24'h0, POINTER_RESET});
    apb(1'b0, 8'h10, 32'h0); // unmapped address is refused
    chk(err, 1'b1);
    // top ratio stays refused in stand-alone mode even with the divide bit stored
    apb(1'b1, OFS_CTRL, CTRL_RESET | (32'h4 << RATIO_LSB) | (32'h1 << MDIV_BIT));
    cyc(2);
    chk(o_ratio_error, 1'b1);
    // every strap code, with pair 2 running but ignored
    for (int c = 0; c < 16; c++) begin
      set_pins(c[3:0]);
      cyc(3);
      chk(o_format_code, {1'b0, c[1:0]});
      chk(o_speed, c[3] ? (c[2] ? SPEED_QUAD : SPEED_DOUBLE) : SPEED_SINGLE);
      chk(o_de_emphasis, c[3:2] == 2'h1);
      chk(o_osr, c[3] ? (c[2] ? OSR_QUAD : OSR_DOUBLE) : OSR_SINGLE);
      chk(o_filter_slow, 1'b0);
      chk(o_data_frame_clock, {3{pins_q[3]}});
      chk(o_data_bit_clock, {3{pins_q[1]}});
    end
    // stream mode from the held frame clock, rate from pins 2:0
    @(posedge i_clk);
    hold_high <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      set_pins({1'b0, k[2:0]});
      cyc(k == 0 ? 270 : 3);
      check_stream(k);
    end
    @(posedge i_clk);
    hold_high <= 1'b0;
    cyc(20); // frame clock 1 may still be in its high half for up to eight cycles
    chk(o_stream_active, 1'b0);
    // stand-alone power-up in single speed
    set_pins(4'h0);
    do_reset();
    cyc(500 * FR);
    chk(o_low_power, 1'b1);
    wait_flag(0, 1'b1, 40 * FR);
    chk(o_quiescent_reference, 1'b1);
    chk(o_low_power, 1'b0);
    // enable mid-sequence halts it and loads defaults
    do_reset();
    cyc(100 * FR);
    apb(1'b1, OFS_CTRL, CONTROL_PORT_ENABLE_BIT_MASK);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, CTRL_RESET | CONTROL_PORT_ENABLE_BIT_MASK);
    cyc(450 * FR);
    chk(o_low_power, 1'b1);
    chk(o_cp_mode, 1'b1);
    // registers rule over straps now; power-down still set
    set_pins(4'hF);
    apb(1'b1, OFS_CTRL, CTRL_RESET | (32'h1 << FILT_BIT) | (32'h2 << FMT_LSB) | (32'h1 << FM_LSB));
    cyc(3);
    chk(o_format_code, 3'h2);
    chk(o_osr, OSR_DOUBLE);
    chk(o_filter_slow, 1'b1);
    chk(o_low_power, 1'b1);
    apb(1'b1, OFS_CTRL, CTRL_RESET | (32'h4 << RATIO_LSB));
    cyc(2);
    chk(o_ratio_error, 1'b1);
    apb(1'b1, OFS_CTRL, CTRL_RESET | (32'h4 << RATIO_LSB) | (32'h1 << MDIV_BIT));
    cyc(2);
    chk(o_ratio_error, 1'b0);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, OFS_CTRL, CTRL_RESET | (32'(FM_STREAM) << FM_LSB) | (32'(k) << FMT_LSB));
      cyc(2);
      check_stream(k);
    end
    ptr_run(8'h81, 8, 8'h88);
    ptr_run(8'h89, 9, 8'h91);
    ptr_run(8'h05, 3, 8'h05);
    ptr_run(8'hFF, 0, 8'h9F);
    // power-down cleared, input 1 on pair 2, mute pin follows mute control
    apb(1'b1, OFS_CTRL, (32'h2 << SRC_LSB) | (32'h1 << MUTE_CONTROL_BITS_LSB));
    cyc(400 * FR);
    chk(o_low_power, 1'b1);
    wait_flag(0, 1'b1, 200 * FR);
    chk(o_dac_active, 1'b1);
    repeat (20) begin
      cyc(1);
      chk(o_data_frame_clock, {pins_q[3], pins_q[2], pins_q[3]});
      chk(o_data_bit_clock, {pins_q[1], pins_q[0], pins_q[1]});
    end
    // one broken frame forces a retime with muting
    @(posedge i_clk);
    glitch <= 1'b1;
    @(posedge i_clk);
    glitch <= 1'b0;
    wait_flag(1, 1'b1, 4 * FR);
    chk(o_dac_active, 1'b0);
    chk(o_mute_pin, 1'b1);
    wait_flag(2, 1'b1, 20 * FR);
    chk(o_mute, 1'b0);
    chk(o_mute_pin, 1'b0);
    print_verdict();
  end
endmodule : tb
